// ==== itc_pkg.sv ====
package itc_pkg;

  // ---------------------------------------------------------------
  // Sources and descriptor field positions
  // ---------------------------------------------------------------
  localparam int NSRC  = 8;
  localparam int MD_HI = 7;
  localparam int MD_LO = 6;
  localparam int SZ_HI = 5;
  localparam int SZ_LO = 4;
  localparam int SM_HI = 3;
  localparam int SM_LO = 2;
  localparam int CHAIN_EN_BIT   = 7;
  localparam int CHAIN_COND_BIT = 6;
  localparam int IRQ_EACH_BIT   = 5;
  localparam int AREA_SIDE_BIT  = 4;
  localparam int DM_HI = 3;
  localparam int DM_LO = 2;

  // ---------------------------------------------------------------
  // Encodings and layout constants
  // ---------------------------------------------------------------
  localparam logic [1:0]  MODE_NORMAL = 2'h0;
  localparam logic [1:0]  MODE_REPEAT = 2'h1;
  localparam logic [1:0]  MODE_BLOCK  = 2'h2;
  localparam logic [1:0]  SZ_BYTE     = 2'h0;
  localparam logic [1:0]  SZ_WORD     = 2'h1;
  localparam logic [1:0]  SZ_LONG     = 2'h2;
  localparam logic [1:0]  LAST_WI_SHORT = 2'h2;
  localparam logic [1:0]  LAST_WI_FULL  = 2'h3;
  localparam logic [31:0] DESC_BYTES_SHORT = 32'h0000_000c;
  localparam logic [31:0] DESC_BYTES_FULL  = 32'h0000_0010;
  localparam logic [31:0] SHORT_MASK = 32'h00ff_ffff;
  localparam logic [31:0] FULL_MASK  = 32'hffff_ffff;
  localparam logic [31:0] ALIGN_MASK = 32'hffff_fffc;

  typedef enum logic [9:0] {
    S_IDLE  = 10'h001,
    S_VEC   = 10'h002,
    S_DRD   = 10'h004,
    S_SETUP = 10'h008,
    S_RD    = 10'h010,
    S_WSET  = 10'h020,
    S_WR    = 10'h040,
    S_UPD   = 10'h080,
    S_WB    = 10'h100,
    S_DONE  = 10'h200
  } itc_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } itc_mem_t;

  typedef struct packed {
    logic [7:0]  transfer_mode_word_a;
    logic [7:0]  transfer_mode_word_b;
    logic [31:0] source_address_word;
    logic [31:0] destination_address_word;
    logic [15:0] count_word_a;
    logic [15:0] count_word_b;
  } itc_desc_t;

  typedef struct packed {
    itc_state_t  st;
    logic [2:0]  vec;
    logic [2:0]  last_vec;
    logic        skip_ok;
    logic        chained;
    logic [31:0] base;
    logic [31:0] desc_addr;
    logic [1:0]  wi;
    itc_desc_t   d;
    logic [31:0] cur;
    logic [2:0]  bl;
    logic [31:0] acc;
    logic        zero;
    logic        endf;
    itc_mem_t    mem;
    logic        irq;
    logic [2:0]  irq_src;
    logic [7:0]  clr;
    logic        busy;
  } itc_ctx_t;

  localparam itc_ctx_t CTX_RST = '{st: S_IDLE, default: '0};
  localparam logic [1:0] FIFO_CNT_RST = 2'h0;

endpackage

// ==== itc_ctrl.sv ====
// How it works
// - An enabled activation request starts a transfer.
// - Read vector, fetch descriptor, move data, write descriptor back.
// - Mode, address and count words exist only in memory descriptors.
// - Chaining runs further descriptors for one activation.
// - Chaining may be made conditional on the counter reaching zero.
// - Mode field: 00 normal, 01 repeat, 10 block, 11 prohibited.
// - Short mode: 3-longword descriptors, 24-bit addresses.
// - Full mode: 4-longword descriptors, 32-bit addresses.
// - Size field: 00 byte, 01 word, 10 longword, 11 prohibited.
// - Word or longword at an odd address is split into smaller cycles.
// - Longword at address 4n+2 is split into two word cycles.
// - Source mode: 0x fixed, 10 increment, 11 decrement by unit size.
// - Writeback of a fixed address word is skipped.
// - Optional skip of descriptor reading on activation.
// - Processor interrupt after each transfer or after the whole count.
// - Descriptor accesses are single 32-bit cycles.
// - Chain select: 0 always, 1 only at zero; chained step clears nothing.
// - Interrupt select 1 interrupts every transfer, 0 only at count end.
// - Area select 0 makes destination the repeat area, 1 the source.
// - Destination steps like the source using its own mode field.
module itc_ctrl (
  input  wire logic             SYS_CLK_I,
  input  wire logic             RESETN_I,
  input  wire logic [7:0]       ACT_REQ_I,
  input  wire logic [7:0]       ACT_EN_I,
  input  wire logic [31:0]      VBR_I,
  input  wire logic             FULL_ADDR_I,
  input  wire logic             READ_SKIP_I,
  input  wire logic             MEM_ACK_I,
  input  wire logic [31:0]      MEM_RDATA_I,
  output itc_pkg::itc_mem_t     MEM_O,
  output logic                  CPU_IRQ_O,
  output logic [2:0]            IRQ_SRC_O,
  output logic [7:0]            ACT_CLR_O,
  output logic                  BUSY_O
);
  import itc_pkg::*;

  // ---------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------
  itc_ctx_t    c_q;
  itc_ctx_t    c_d;
  logic [31:0] fb_q [2];
  logic        wp_q;
  logic        rp_q;
  logic [1:0]  fcnt_q;

  function automatic logic [2:0] pick_lowest(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // The source being cleared or interrupted is masked for the cycle its pulse stands,
  // because the requester can only drop its level one edge later.
  wire [7:0]  held    = c_q.clr | (c_q.irq ? (8'h01 << c_q.irq_src) : 8'h00);
  wire [7:0]  hits    = ACT_REQ_I & ACT_EN_I & ~held;
  wire [2:0]  pick    = pick_lowest(hits);
  wire        ack     = MEM_ACK_I && c_q.mem.req;
  wire [1:0]  md_raw  = c_q.d.transfer_mode_word_a[MD_HI:MD_LO];
  // Prohibited codes fall back to normal mode and byte size.
  wire [1:0]  md      = (md_raw == 2'h3) ? MODE_NORMAL : md_raw;
  wire [1:0]  sz_raw  = c_q.d.transfer_mode_word_a[SZ_HI:SZ_LO];
  wire [1:0]  sz      = (sz_raw == 2'h3) ? SZ_BYTE : sz_raw;
  wire [1:0]  sm      = c_q.d.transfer_mode_word_a[SM_HI:SM_LO];
  wire [1:0]  dm      = c_q.d.transfer_mode_word_b[DM_HI:DM_LO];
  wire        chain_en   = c_q.d.transfer_mode_word_b[CHAIN_EN_BIT];
  wire        chain_cond = c_q.d.transfer_mode_word_b[CHAIN_COND_BIT];
  wire        irq_each   = c_q.d.transfer_mode_word_b[IRQ_EACH_BIT];
  wire        area_src   = c_q.d.transfer_mode_word_b[AREA_SIDE_BIT];
  wire [31:0] step    = {29'h0, sz == SZ_LONG, sz == SZ_WORD, sz == SZ_BYTE};
  wire [2:0]  nb      = step[2:0];
  wire [31:0] amask   = FULL_ADDR_I ? FULL_MASK : SHORT_MASK;
  wire [1:0]  last_wi = FULL_ADDR_I ? LAST_WI_FULL : LAST_WI_SHORT;
  wire [31:0] dbytes  = FULL_ADDR_I ? DESC_BYTES_FULL : DESC_BYTES_SHORT;

  // ---------------------------------------------------------------
  // Bus cycle splitting
  // ---------------------------------------------------------------
  // A unit is cut into the largest naturally aligned pieces, so an odd word
  // degrades to byte cycles, an odd longword to byte, word, byte, and 4n+2 to word cycles.
  wire        is_long = (c_q.bl == 3'h4) && (c_q.cur[1:0] == 2'h0);
  wire        is_word = !is_long && (c_q.bl >= 3'h2) && !c_q.cur[0];
  wire [2:0]  pb      = is_long ? 3'h4 : (is_word ? 3'h2 : 3'h1);
  wire [1:0]  psz     = is_long ? SZ_LONG : (is_word ? SZ_WORD : SZ_BYTE);
  wire [31:0] rmask   = is_long ? 32'hffff_ffff : (is_word ? 32'h0000_ffff : 32'h0000_00ff);
  wire        last_pc = (pb == c_q.bl);
  wire [31:0] rd_acc  = (c_q.acc << {pb, 3'b000}) | (MEM_RDATA_I & rmask);
  wire [2:0]  wsh     = c_q.bl - pb;
  wire [31:0] head    = fb_q[rp_q];
  wire [31:0] wr_data = (head >> {wsh, 3'b000}) & rmask;
  wire [31:0] cur_nx  = (c_q.cur + {29'h0, pb}) & amask;

  // ---------------------------------------------------------------
  // Two-entry data buffer
  // ---------------------------------------------------------------
  // The read side stalls in S_SETUP while the buffer is full, so a write
  // side that waits for its acknowledge never drops a word.
  wire fifo_rdy = (fcnt_q != 2'h2);
  wire fifo_vld = (fcnt_q != 2'h0);
  wire push     = (c_q.st == S_RD) && ack && last_pc;
  wire pop      = (c_q.st == S_WR) && ack && last_pc;

  for (genvar g = 0; g < 2; g++) begin : g_fb
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
        fb_q[g] <= '0;
      end else if (push && (wp_q == 1'(g))) begin
        fb_q[g] <= rd_acc;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wp_q   <= 1'b0;
      rp_q   <= 1'b0;
      fcnt_q <= FIFO_CNT_RST;
    end else begin
      wp_q   <= wp_q ^ push;
      rp_q   <= rp_q ^ pop;
      fcnt_q <= fcnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // ---------------------------------------------------------------
  // Address and count update
  // ---------------------------------------------------------------
  wire [7:0]  hi      = c_q.d.count_word_a[15:8];
  wire [7:0]  lo_n    = c_q.d.count_word_a[7:0] - 8'h01;
  wire [15:0] cra_m1  = c_q.d.count_word_a - 16'h0001;
  wire [15:0] crb_m1  = c_q.d.count_word_b - 16'h0001;
  wire        wrap    = (md != MODE_NORMAL) && (lo_n == 8'h00);
  wire [31:0] delta   = {24'h0, hi} * {29'h0, nb};
  wire [31:0] sar_stp = sm[1] ? (sm[0] ? c_q.d.source_address_word - step : c_q.d.source_address_word + step) : c_q.d.source_address_word;
  wire [31:0] dar_stp = dm[1] ? (dm[0] ? c_q.d.destination_address_word - step : c_q.d.destination_address_word + step) : c_q.d.destination_address_word;
  wire [31:0] sar_rev = sm[0] ? sar_stp + delta : sar_stp - delta;
  wire [31:0] dar_rev = dm[0] ? dar_stp + delta : dar_stp - delta;
  // The repeat or block area returns to its start when the inner count wraps.
  wire [31:0] sar_n   = ((wrap && area_src && sm[1]) ? sar_rev : sar_stp) & amask;
  wire [31:0] dar_n   = ((wrap && !area_src && dm[1]) ? dar_rev : dar_stp) & amask;
  wire [15:0] cra_n   = (md == MODE_NORMAL) ? cra_m1 : (wrap ? {hi, hi} : {hi, lo_n});
  wire [15:0] crb_n   = ((md == MODE_BLOCK) && wrap) ? crb_m1 : c_q.d.count_word_b;
  wire        endf_n  = (md == MODE_NORMAL) ? (cra_m1 == 16'h0000) :
                        ((md == MODE_BLOCK) && wrap && (crb_m1 == 16'h0000));
  wire        zero_n  = (md == MODE_REPEAT) ? wrap : endf_n;
  wire        blk_more = (md == MODE_BLOCK) && !wrap;
  wire        chain_go = chain_en && (!chain_cond || c_q.zero);

  // ---------------------------------------------------------------
  // Descriptor writeback
  // ---------------------------------------------------------------
  // Mode words never change, so in full mode their word is not rewritten.
  wire        wb_need = FULL_ADDR_I ?
                        ((c_q.wi == 2'h1) ? sm[1] : (c_q.wi == 2'h2) ? dm[1] : (c_q.wi == 2'h3)) :
                        ((c_q.wi == 2'h0) ? sm[1] : (c_q.wi == 2'h1) ? dm[1] : 1'b1);
  wire [31:0] wb_word = FULL_ADDR_I ?
                        ((c_q.wi == 2'h1) ? c_q.d.source_address_word : (c_q.wi == 2'h2) ? c_q.d.destination_address_word :
                         {c_q.d.count_word_a, c_q.d.count_word_b}) :
                        ((c_q.wi == 2'h0) ? {c_q.d.transfer_mode_word_a, c_q.d.source_address_word[23:0]} :
                         (c_q.wi == 2'h1) ? {c_q.d.transfer_mode_word_b, c_q.d.destination_address_word[23:0]} : {c_q.d.count_word_a, c_q.d.count_word_b});
  wire        wb_adv  = !wb_need || ack;
  wire [31:0] vec_adr = VBR_I + {27'h0, c_q.vec, 2'b00};
  wire [31:0] dsc_adr = c_q.desc_addr + {28'h0, c_q.wi, 2'b00};

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    c_d     = c_q;
    c_d.irq = 1'b0;
    c_d.clr = '0;
    if (ack) begin
      c_d.mem.req = 1'b0;
    end
    case (c_q.st)
      S_IDLE: begin
        c_d.busy = 1'b0;
        if (|hits) begin
          c_d.vec     = pick;
          c_d.busy    = 1'b1;
          c_d.chained = 1'b0;
          c_d.wi      = 2'h0;
          if (READ_SKIP_I && c_q.skip_ok && (pick == c_q.last_vec)) begin
            c_d.desc_addr = c_q.base;
            c_d.st        = S_SETUP;
          end else begin
            c_d.st = S_VEC;
          end
        end
      end
      S_VEC: begin
        if (!c_q.mem.req) begin
          c_d.mem = '{req: 1'b1, we: 1'b0, size: SZ_LONG, addr: vec_adr, wdata: '0};
        end
        if (ack) begin
          c_d.desc_addr = MEM_RDATA_I & amask & ALIGN_MASK;
          c_d.base      = MEM_RDATA_I & amask & ALIGN_MASK;
          c_d.st        = S_DRD;
        end
      end
      S_DRD: begin
        if (!c_q.mem.req) begin
          c_d.mem = '{req: 1'b1, we: 1'b0, size: SZ_LONG, addr: dsc_adr, wdata: '0};
        end
        if (ack) begin
          // Reserved mode bits are stored but never decoded.
          if (FULL_ADDR_I) begin
            case (c_q.wi)
              2'h0: begin
                c_d.d.transfer_mode_word_a = MEM_RDATA_I[31:24];
                c_d.d.transfer_mode_word_b = MEM_RDATA_I[23:16];
              end
              2'h1: c_d.d.source_address_word = MEM_RDATA_I;
              2'h2: c_d.d.destination_address_word = MEM_RDATA_I;
              default: {c_d.d.count_word_a, c_d.d.count_word_b} = MEM_RDATA_I;
            endcase
          end else begin
            case (c_q.wi)
              2'h0: begin
                c_d.d.transfer_mode_word_a = MEM_RDATA_I[31:24];
                c_d.d.source_address_word = {8'h00, MEM_RDATA_I[23:0]};
              end
              2'h1: begin
                c_d.d.transfer_mode_word_b = MEM_RDATA_I[31:24];
                c_d.d.destination_address_word = {8'h00, MEM_RDATA_I[23:0]};
              end
              default: {c_d.d.count_word_a, c_d.d.count_word_b} = MEM_RDATA_I;
            endcase
          end
          c_d.wi = c_q.wi + 2'h1;
          if (c_q.wi == last_wi) begin
            c_d.wi = 2'h0;
            c_d.st = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        if (fifo_rdy) begin
          c_d.bl  = nb;
          c_d.cur = c_q.d.source_address_word & amask;
          c_d.acc = '0;
          c_d.st  = S_RD;
        end
      end
      S_RD: begin
        if (!c_q.mem.req) begin
          c_d.mem = '{req: 1'b1, we: 1'b0, size: psz, addr: c_q.cur, wdata: '0};
        end
        if (ack) begin
          c_d.acc = rd_acc;
          c_d.cur = cur_nx;
          c_d.bl  = c_q.bl - pb;
          if (last_pc) begin
            c_d.st = S_WSET;
          end
        end
      end
      S_WSET: begin
        c_d.bl  = nb;
        c_d.cur = c_q.d.destination_address_word & amask;
        c_d.st  = S_WR;
      end
      S_WR: begin
        if (!c_q.mem.req && fifo_vld) begin
          c_d.mem = '{req: 1'b1, we: 1'b1, size: psz, addr: c_q.cur, wdata: wr_data};
        end
        if (ack) begin
          c_d.cur = cur_nx;
          c_d.bl  = c_q.bl - pb;
          if (last_pc) begin
            c_d.st = S_UPD;
          end
        end
      end
      S_UPD: begin
        c_d.d.source_address_word = sar_n;
        c_d.d.destination_address_word = dar_n;
        c_d.d.count_word_a = cra_n;
        c_d.d.count_word_b = crb_n;
        c_d.zero  = zero_n;
        c_d.endf  = endf_n;
        c_d.wi    = 2'h0;
        c_d.st    = blk_more ? S_SETUP : S_WB;
      end
      S_WB: begin
        if (wb_need && !c_q.mem.req) begin
          c_d.mem = '{req: 1'b1, we: 1'b1, size: SZ_LONG, addr: dsc_adr, wdata: wb_word};
        end
        if (wb_adv) begin
          c_d.wi = c_q.wi + 2'h1;
          if (c_q.wi == last_wi) begin
            c_d.st = S_DONE;
          end
        end
      end
      S_DONE: begin
        if (chain_go) begin
          c_d.desc_addr = c_q.desc_addr + dbytes;
          c_d.chained   = 1'b1;
          c_d.wi        = 2'h0;
          c_d.st        = S_DRD;
        end else begin
          if (irq_each || c_q.endf) begin
            c_d.irq     = 1'b1;
            c_d.irq_src = c_q.vec;
          end else begin
            c_d.clr = 8'h01 << c_q.vec;
          end
          // A chained run leaves the held descriptor unlike the first one.
          c_d.skip_ok  = !c_q.chained;
          c_d.last_vec = c_q.vec;
          c_d.st       = S_IDLE;
        end
      end
      default: c_d = CTX_RST;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      c_q <= CTX_RST;
    end else begin
      c_q <= c_d;
    end
  end

  assign MEM_O     = c_q.mem;
  assign CPU_IRQ_O = c_q.irq;
  assign IRQ_SRC_O = c_q.irq_src;
  assign ACT_CLR_O = c_q.clr;
  assign BUSY_O    = c_q.busy;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  sequence s_vec_ack;
    (c_q.st == S_VEC) && ack;
  endsequence

  sequence s_desc_start;
    (c_q.st == S_DRD) && (c_q.desc_addr[1:0] == 2'h0);
  endsequence

  a_act_start: assert property ((c_q.st == S_IDLE) && (|hits) |=> (c_q.st inside {S_VEC, S_SETUP}))
    else $error("enabled request did not start a transfer");
  a_vec_fetch: assert property ((c_q.st == S_VEC) && c_q.mem.req |-> !c_q.mem.we && (c_q.mem.addr == vec_adr))
    else $error("vector read has wrong address");
  a_vec_to_desc: assert property (s_vec_ack |=> s_desc_start ##1 (c_q.mem.req && !c_q.mem.we))
    else $error("descriptor fetch did not follow vector read");
  a_desc_readonly: assert property ((c_q.st inside {S_VEC, S_DRD}) && c_q.mem.req |-> !c_q.mem.we)
    else $error("write during descriptor fetch");
  a_desc_longword: assert property ((c_q.st inside {S_VEC, S_DRD, S_WB}) && c_q.mem.req |-> (c_q.mem.size == SZ_LONG))
    else $error("descriptor access not a single longword");
  a_long_align: assert property (c_q.mem.req && (c_q.mem.size == SZ_LONG) |-> (c_q.mem.addr[1:0] == 2'h0))
    else $error("unaligned longword cycle");
  a_word_align: assert property (c_q.mem.req && (c_q.mem.size == SZ_WORD) |-> !c_q.mem.addr[0])
    else $error("odd word cycle");
  a_short_space: assert property (!FULL_ADDR_I && (c_q.st inside {S_RD, S_WR}) && c_q.mem.req
                                  |-> (c_q.mem.addr[31:24] == 8'h00))
    else $error("short mode address above 24 bits");
  a_wb_skip: assert property ((c_q.st == S_WB) && c_q.mem.req && FULL_ADDR_I && (c_q.wi == 2'h1) |-> sm[1])
    else $error("fixed source address written back");
  a_irq_pulse: assert property (c_q.irq |-> (irq_each || c_q.endf) ##1 (!c_q.irq && (c_q.st == S_IDLE)))
    else $error("interrupt without cause or longer than one cycle");
  a_chain_always: assert property ((c_q.st == S_DONE) && chain_en && !chain_cond |=> (c_q.st == S_DRD) && !c_q.irq)
    else $error("unconditional chain not taken");

endmodule

// ==== itc_mem_model.sv ====
module itc_mem_model (
  input  logic               clk_i,
  input  logic               rstn_i,
  input  itc_pkg::itc_mem_t  mem_i,
  input  logic [3:0]         dly_i,
  output logic               ack_o,
  output logic [31:0]        rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import itc_pkg::*;

  logic [7:0]  mem [logic [31:0]];
  logic [3:0]  cnt_q;
  logic [31:0] last_q;
  int          n;
  int          rd_cnt;
  int          wr_cnt;

  // Memory is big-endian: the lowest address holds the most significant byte.
  function automatic logic [31:0] rd(input logic [31:0] a, input int k);
    rd = 32'h0000_0000;
    for (int i = 0; i < k; i++) begin
      rd = {rd[23:0], mem.exists(a + i) ? mem[a + i] : 8'h00};
    end
  endfunction

  task automatic wr(input logic [31:0] a, input int k, input logic [31:0] v);
    for (int i = 0; i < k; i++) begin
      mem[a + i] = 8'(v >> (8 * (k - 1 - i)));
    end
  endtask

  assign n = (mem_i.size == 2'h0) ? 1 : (mem_i.size == 2'h1) ? 2 : 4;
  // Outside the answer cycle the data lines carry junk, never the last word.
  assign rdata_o = ack_o ? last_q : ~last_q;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o  <= 1'b0;
      cnt_q  <= 4'h0;
      last_q <= 32'h0000_0000;
    end else if (mem_i.req && !ack_o && cnt_q >= dly_i) begin
      ack_o <= 1'b1;
      cnt_q <= 4'h0;
      if (mem_i.we) begin
        wr(mem_i.addr, n, mem_i.wdata);
        wr_cnt++;
      end else begin
        last_q <= rd(mem_i.addr, n);
        rd_cnt++;
      end
    end else begin
      ack_o <= 1'b0;
      cnt_q <= mem_i.req ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== test_interrupt_driven_transfer_controller.sv ====
module test_interrupt_driven_transfer_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import itc_pkg::*;

  logic        clk, rstn, full, skip, ack, irq, busy;
  logic [7:0]  req, raise, en, clr, clr_seen;
  logic [31:0] rdata;
  logic [2:0]  isrc;
  logic [3:0]  dly;
  itc_mem_t    mem_bus;
  int          err_count, total_checks, irq_cnt, rd0, wr0;

  itc_ctrl u_dut (.SYS_CLK_I(clk), .RESETN_I(rstn), .ACT_REQ_I(req), .ACT_EN_I(en),
    .VBR_I(32'h0000_1000), .FULL_ADDR_I(full), .READ_SKIP_I(skip), .MEM_ACK_I(ack),
    .MEM_RDATA_I(rdata), .MEM_O(mem_bus), .CPU_IRQ_O(irq), .IRQ_SRC_O(isrc),
    .ACT_CLR_O(clr), .BUSY_O(busy));

  itc_mem_model u_mem (.clk_i(clk), .rstn_i(rstn), .mem_i(mem_bus), .dly_i(dly),
    .ack_o(ack), .rdata_o(rdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Acting as interrupt controller: a clear pulse or a served interrupt drops the request.
  always @(posedge clk) begin
    clr_seen = clr_seen | clr;
    if (irq === 1'b1) irq_cnt++;
    req <= (req | raise) & ~clr & ~((irq === 1'b1) ? 8'(1 << isrc) : 8'h00);
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic act(input int s, input logic [7:0] exp_clr, input int exp_irq);
    int k;
    @(negedge clk);
    clr_seen = 8'h00;
    irq_cnt = 0;
    rd0 = u_mem.rd_cnt;
    wr0 = u_mem.wr_cnt;
    @(posedge clk);
    raise <= 8'(1 << s);
    @(posedge clk);
    raise <= 8'h00;
    k = 0;
    while (busy !== 1'b1 && k < 10) begin @(posedge clk); k++; end
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin @(posedge clk); k++; end
    repeat (3) @(posedge clk);
    check("clear pulse", {24'h00_0000, exp_clr}, {24'h00_0000, clr_seen});
    check("irq count", 32'(exp_irq), 32'(irq_cnt));
  endtask

  task automatic fdesc(input logic [31:0] a, input logic [7:0] ma, input logic [7:0] mb,
                       input logic [31:0] sa, input logic [31:0] da, input logic [31:0] cw);
    u_mem.wr(a, 4, {ma, mb, 16'h0000});
    u_mem.wr(a + 32'h0000_0004, 4, sa);
    u_mem.wr(a + 32'h0000_0008, 4, da);
    u_mem.wr(a + 32'h0000_000c, 4, cw);
  endtask

  task automatic t_enable();
    act(6, 8'h00, 0);
    check("idle reads", 32'h0000_0000, 32'(u_mem.rd_cnt - rd0));
    $display("t_enable done");
  endtask

  task automatic t_full_long();
    fdesc(32'h0000_0200, 8'h28, 8'h00, 32'h0000_3002, 32'h0000_4000, 32'h0002_0000);
    u_mem.wr(32'h0000_100c, 4, 32'h0000_0200);
    u_mem.wr(32'h0000_3002, 4, 32'h1122_3344);
    u_mem.wr(32'h0000_3006, 4, 32'h5566_7788);
    act(3, 8'h08, 0);
    check("long data", 32'h1122_3344, u_mem.rd(32'h0000_4000, 4));
    check("src wb", 32'h0000_3006, u_mem.rd(32'h0000_0204, 4));
    check("count wb", 32'h0001_0000, u_mem.rd(32'h0000_020c, 4));
    check("reads", 32'h0000_0007, 32'(u_mem.rd_cnt - rd0));
    check("writes", 32'h0000_0003, 32'(u_mem.wr_cnt - wr0));
    act(3, 8'h00, 1);
    check("irq src", 32'h0000_0003, {29'h0, isrc});
    check("long data 2", 32'h5566_7788, u_mem.rd(32'h0000_4000, 4));
    check("count end", 32'h0000_0000, u_mem.rd(32'h0000_020c, 4));
    $display("t_full_long done");
  endtask

  task automatic t_short_word();
    @(posedge clk);
    full <= 1'b0;
    dly <= 4'h3;
    u_mem.wr(32'h0000_1014, 4, 32'h0000_0300);
    u_mem.wr(32'h0000_0300, 4, 32'h1000_5001);
    u_mem.wr(32'h0000_0304, 4, 32'h2c00_6002);
    u_mem.wr(32'h0000_0308, 4, 32'h0005_0000);
    u_mem.wr(32'h0000_5001, 2, 32'h0000_aabb);
    act(5, 8'h00, 1);
    check("odd word", 32'h0000_aabb, u_mem.rd(32'h0000_6002, 2));
    check("dst wb", 32'h2c00_6000, u_mem.rd(32'h0000_0304, 4));
    check("count wb", 32'h0004_0000, u_mem.rd(32'h0000_0308, 4));
    check("reads", 32'h0000_0006, 32'(u_mem.rd_cnt - rd0));
    check("writes", 32'h0000_0003, 32'(u_mem.wr_cnt - wr0));
    check("irq src", 32'h0000_0005, {29'h0, isrc});
    @(posedge clk);
    full <= 1'b1;
    dly <= 4'h0;
    $display("t_short_word done");
  endtask

  task automatic t_chain();
    fdesc(32'h0000_0400, 8'h08, 8'hc8, 32'h0000_7000, 32'h0000_7100, 32'h0002_0000);
    fdesc(32'h0000_0410, 8'h08, 8'h08, 32'h0000_7200, 32'h0000_7300, 32'h0001_0000);
    u_mem.wr(32'h0000_1000, 4, 32'h0000_0400);
    u_mem.wr(32'h0000_7000, 2, 32'h0000_0102);
    u_mem.wr(32'h0000_7200, 1, 32'h0000_005a);
    act(0, 8'h01, 0);
    check("no chain", 32'h0000_0000, u_mem.rd(32'h0000_7300, 1));
    act(0, 8'h00, 1);
    check("first", 32'h0000_0102, u_mem.rd(32'h0000_7100, 2));
    check("chained", 32'h0000_005a, u_mem.rd(32'h0000_7300, 1));
    $display("t_chain done");
  endtask

  task automatic t_repeat();
    fdesc(32'h0000_0500, 8'h48, 8'h08, 32'h0000_7400, 32'h0000_7500, 32'h0202_0000);
    u_mem.wr(32'h0000_1004, 4, 32'h0000_0500);
    u_mem.wr(32'h0000_7400, 2, 32'h0000_7788);
    act(1, 8'h02, 0);
    @(posedge clk);
    skip <= 1'b1;
    act(1, 8'h02, 0);
    check("skip reads", 32'h0000_0001, 32'(u_mem.rd_cnt - rd0));
    check("repeat data", 32'h0000_7788, u_mem.rd(32'h0000_7500, 2));
    check("src wb", 32'h0000_7402, u_mem.rd(32'h0000_0504, 4));
    check("dst back", 32'h0000_7500, u_mem.rd(32'h0000_0508, 4));
    check("reload", 32'h0202_0000, u_mem.rd(32'h0000_050c, 4));
    @(posedge clk);
    skip <= 1'b0;
    $display("t_repeat done");
  endtask

  task automatic t_block();
    fdesc(32'h0000_0600, 8'h98, 8'h18, 32'h0000_7600, 32'h0000_7700, 32'h0202_0001);
    u_mem.wr(32'h0000_1008, 4, 32'h0000_0600);
    u_mem.wr(32'h0000_7600, 4, 32'h1122_3344);
    act(2, 8'h00, 1);
    check("block data", 32'h1122_3344, u_mem.rd(32'h0000_7700, 4));
    check("dst wb", 32'h0000_7704, u_mem.rd(32'h0000_0608, 4));
    check("blocks left", 32'h0000_0000, u_mem.rd(32'h0000_060e, 2));
    $display("t_block done");
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    close_out();
  end

  // Descriptors sit in plain memory here, so no on-chip RAM enable is needed.
  initial begin
    rstn = 1'b0;
    full = 1'b1;
    skip = 1'b0;
    dly = 4'h0;
    req = 8'h00;
    raise = 8'h00;
    en = 8'hbf;
    clr_seen = 8'h00;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_enable();
    t_full_long();
    t_short_word();
    t_chain();
    t_repeat();
    t_block();
    close_out();
  end
endmodule
